// ===== verilog/wq_defines.vh
/*
 Weld quality error counter constants: register byte offsets, field
 positions, reset values, message codes and timing figures.
 Assumes inclusion by bare name from the design file.
*/
`ifndef WQ_DEFINES_VH
`define WQ_DEFINES_VH
`define WQ_REG_CTRL 8'h00
`define WQ_REG_PW_PROG 8'h04
`define WQ_REG_LIM_PROG 8'h08
`define WQ_REG_PW_COMP 8'h0C
`define WQ_REG_LIM_COMP 8'h10
`define WQ_REG_PW_SER 8'h14
`define WQ_REG_LIM_SER 8'h18
`define WQ_REG_CLEAR 8'h1C
`define WQ_REG_STATUS 8'h20
`define WQ_REG_CNT_COMP 8'h24
`define WQ_REG_CNT_SER 8'h28
`define WQ_REG_SEL 8'h2C
`define WQ_REG_CNT_PROG 8'h30
`define WQ_REG_SP_PROC 8'h34
`define WQ_REG_SP_RATE 8'h38
`define WQ_REG_SP_TIME 8'h3C
`define WQ_REG_DELAY 8'h40
`define WQ_REG_DIP 8'h44
`define WQ_REG_DEPTH 8'h48
`define WQ_CTRL_MODE_LSB 0
`define WQ_CTRL_MEN_LSB 8
`define WQ_CLR_ALL_PROG 0
`define WQ_CLR_ONE_PROG 1
`define WQ_CLR_COUNTERS 2
`define WQ_CLR_IDX_LSB 8
`define WQ_SP_OFF 2'h0
`define WQ_SP_ON 2'h1
`define WQ_SP_PAUSE 2'h2
`define WQ_MON_SP 5
`define WQ_MSG_PROG 10'h18D
`define WQ_MSG_COMP 10'h18E
`define WQ_MSG_SER 10'h18F
`define WQ_RST_LIMIT 16'h000A
`define WQ_RST_PREWARN 16'h0005
`define WQ_RST_DEPTH 16'h0064
`define WQ_RST_DIP 12'h040
`define WQ_MAX_MS 13'h1B58
`define WQ_RATE_SCALE 10'h3E8
`define WQ_MS_NS 1000000
`define WQ_CLK_NS 100
`endif

// ===== verilog/wq_error_counters.v
/*
 Weld quality supervision: per-program, component and series fault
 counters with limits, plus the spatter statistics unit, behind an
 Avalon-MM slave with waitrequest.
 Assumes monitor, spot and voltage inputs come from logic on the same
 clock; only the external counter clear arrives asynchronously.
*/
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
//
// Function
// - Per-program counter, up on fault, down on good
// - Program counters clear all or one at a time
// - Component counter counts faults, clear input zeroes
// - Series counter up/down, clear input zeroes it
// - Limit reached raises message and output signal
// - Saturate at limit; one good spot leaves it (program and series counters)
// - Counters never drop below zero
// - Several monitors on one spot count once
// - Limit message never stops welding
// - Own pre-warning and limit per counter
// - Message codes 397, 398, 399
// - Only activated monitors feed the counters
// - Evaluate only processes with current flow
// - Report spatter instant 0-7000 ms or none
// - Spatter rate per program, tenth of percent
// - Process count grows up to rate depth
// - Process count held within 0 to 65535
// - Switching spatter monitor off clears rate
// - Pause stops evaluation, keeps counts
// - Delay zero means automatic, else manual ms
// - Sensitivity set by voltage-drop threshold
// - Significant voltage dip flags spatter
`include "wq_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module wq_error_counters #(
   parameter integer NPROG = 16,
   parameter integer PW = 4,
   parameter integer CW = 16,
   parameter integer NMON = 8,
   parameter integer VW = 12,
   parameter integer MS_CYC = `WQ_MS_NS / `WQ_CLK_NS,
   parameter [12:0] AUTO_DELAY_MS = 13'h0014
) (
   input wire clock,
   input wire rst,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire fault_counter_clear,
   input wire [NMON-1:0] mon_fault,
   input wire spot_done,
   input wire [PW-1:0] spot_prog,
   input wire weld_active,
   input wire weld_current,
   input wire volt_valid,
   input wire [VW-1:0] weld_volt,
   output reg [2:0] limit_out,
   output reg [2:0] prewarn_out,
   output reg msg_valid,
   output reg [9:0] msg_code,
   output reg sp_report,
   output reg sp_none,
   output reg [12:0] sp_time_ms
);
   localparam [NMON-1:0] SP_BIT = {{(NMON-1){1'b0}}, 1'b1} << `WQ_MON_SP;
   integer i;

   reg [1:0] sp_mode_q;
   reg [NMON-1:0] mon_en_q;
   reg [PW-1:0] sel_q;
   reg [CW-1:0] pw_q [0:2];
   reg [CW-1:0] lim_q [0:2];
   reg [12:0] delay_q;
   reg [VW-1:0] dip_q;
   reg [15:0] depth_q;
   reg [CW-1:0] prog_cnt_q [0:NPROG-1];
   reg [CW-1:0] comp_q;
   reg [CW-1:0] ser_q;
   reg [15:0] proc_q [0:NPROG-1];
   reg [15:0] spat_q [0:NPROG-1];
   reg [PW-1:0] last_prog_q;
   reg [1:0] clr_sync_q;
   reg [1:0] hit_prev_q;
   reg [2:0] msg_pend_q;
   reg prog_reach_q;
   reg [15:0] rate_q;

   // Spatter process tracking
   reg act_prev_q;
   reg cur_seen_q;
   reg sp_hit_q;
   reg [12:0] sp_at_q;
   reg [12:0] ms_q;
   reg [15:0] tick_q;
   reg [VW-1:0] prev_v_q;
   reg have_prev_q;

   wire bus_take = (avs_read | avs_write) & avs_waitrequest;
   wire wr_go = avs_write & ~avs_waitrequest;
   wire soft_clr = wr_go & (avs_address == `WQ_REG_CLEAR);
   wire cnt_clr = clr_sync_q[1] |
      (soft_clr & avs_writedata[`WQ_CLR_COUNTERS]);
   wire [PW-1:0] clr_idx = avs_writedata[`WQ_CLR_IDX_LSB+PW-1:
      `WQ_CLR_IDX_LSB];

   function [CW-1:0] step;
      input [CW-1:0] cnt;
      input [CW-1:0] lim;
      input f;
      input g;
      begin
         step = cnt;
         if (f && cnt < lim)
            step = cnt + 1'b1;
         else if (g && cnt != {CW{1'b0}})
            step = cnt - 1'b1;
      end
   endfunction

   // Spatter monitor is evaluated only when on and current flowed
   wire sp_eval = (sp_mode_q == `WQ_SP_ON) & cur_seen_q;
   wire [NMON-1:0] active = mon_en_q & ~(sp_eval ? {NMON{1'b0}} :
      SP_BIT);
   wire [NMON-1:0] src = (mon_fault & ~SP_BIT) |
      (sp_hit_q ? SP_BIT : {NMON{1'b0}});
   // A spot flagged by many monitors is still one fault
   wire spot_fault = spot_done & |(src & active);
   wire spot_good = spot_done & |active & ~spot_fault;
   wire [CW-1:0] prog_next = step(prog_cnt_q[spot_prog], lim_q[0],
      spot_fault, spot_good);

   wire [12:0] delay_eff = (delay_q == 13'h0000) ? AUTO_DELAY_MS :
      delay_q;
   wire dip = volt_valid & have_prev_q & (prev_v_q > weld_volt) &
      ((prev_v_q - weld_volt) > dip_q);

   wire [CW-1:0] prog_view = prog_cnt_q[sel_q];
   wire [CW-1:0] prog_last = prog_cnt_q[last_prog_q];
   wire [2:0] hit = {ser_q >= lim_q[2], comp_q >= lim_q[1],
      prog_last >= lim_q[0]};
   wire [2:0] warn = {ser_q >= pw_q[2], comp_q >= pw_q[1],
      prog_last >= pw_q[0]};
   // The program flag follows the last spot, so its edge is no crossing
   wire [2:0] pend_set = {hit[2:1] & ~hit_prev_q, prog_reach_q};
   wire [2:0] pend_all = msg_pend_q | pend_set;

   wire [25:0] rate_num = spat_q[sel_q] * `WQ_RATE_SCALE;
   wire [15:0] rate_den = proc_q[sel_q];
   wire [25:0] rate_div = (rate_den == 16'h0000) ? 26'h0000000 :
      rate_num / rate_den;

   // The clear pin comes from outside the clock domain
   always @(posedge clock) begin
      if (rst)
         clr_sync_q <= 2'h0;
      else
         clr_sync_q <= {clr_sync_q[0], fault_counter_clear};
   end

   // Register slave: every access answers on the second edge
   always @(posedge clock) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         avs_waitrequest <= ~bus_take;
         if (bus_take && avs_read) begin
            case (avs_address)
               `WQ_REG_CTRL: avs_readdata <= {16'h0000, mon_en_q,
                  6'h00, sp_mode_q};
               `WQ_REG_PW_PROG: avs_readdata <= {{(32-CW){1'b0}}, pw_q[0]};
               `WQ_REG_LIM_PROG: avs_readdata <= {{(32-CW){1'b0}}, lim_q[0]};
               `WQ_REG_PW_COMP: avs_readdata <= {{(32-CW){1'b0}}, pw_q[1]};
               `WQ_REG_LIM_COMP: avs_readdata <= {{(32-CW){1'b0}}, lim_q[1]};
               `WQ_REG_PW_SER: avs_readdata <= {{(32-CW){1'b0}}, pw_q[2]};
               `WQ_REG_LIM_SER: avs_readdata <= {{(32-CW){1'b0}}, lim_q[2]};
               `WQ_REG_STATUS: avs_readdata <= {26'h0000000,
                  prewarn_out, limit_out};
               `WQ_REG_CNT_COMP: avs_readdata <= {{(32-CW){1'b0}}, comp_q};
               `WQ_REG_CNT_SER: avs_readdata <= {{(32-CW){1'b0}}, ser_q};
               `WQ_REG_SEL: avs_readdata <= {{(32-PW){1'b0}}, sel_q};
               `WQ_REG_CNT_PROG: avs_readdata <= {{(32-CW){1'b0}},
                  prog_view};
               `WQ_REG_SP_PROC: avs_readdata <= {16'h0000, proc_q[sel_q]};
               `WQ_REG_SP_RATE: avs_readdata <= {16'h0000, rate_q};
               `WQ_REG_SP_TIME: avs_readdata <= {18'h00000, sp_none,
                  sp_time_ms};
               `WQ_REG_DELAY: avs_readdata <= {19'h00000, delay_q};
               `WQ_REG_DIP: avs_readdata <= {{(32-VW){1'b0}}, dip_q};
               `WQ_REG_DEPTH: avs_readdata <= {16'h0000, depth_q};
               default: avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Configuration registers
   always @(posedge clock) begin
      if (rst) begin
         sp_mode_q <= `WQ_SP_OFF;
         mon_en_q <= {NMON{1'b0}};
         sel_q <= {PW{1'b0}};
         for (i = 0; i < 3; i = i + 1) begin
            pw_q[i] <= `WQ_RST_PREWARN;
            lim_q[i] <= `WQ_RST_LIMIT;
         end
         delay_q <= 13'h0000;
         dip_q <= `WQ_RST_DIP;
         depth_q <= `WQ_RST_DEPTH;
      end else if (wr_go) begin
         case (avs_address)
            `WQ_REG_CTRL: begin
               sp_mode_q <= avs_writedata[`WQ_CTRL_MODE_LSB+1:
                  `WQ_CTRL_MODE_LSB];
               mon_en_q <= avs_writedata[`WQ_CTRL_MEN_LSB+NMON-1:
                  `WQ_CTRL_MEN_LSB];
            end
            // Each counter keeps its own thresholds
            `WQ_REG_PW_PROG: pw_q[0] <= avs_writedata[CW-1:0];
            `WQ_REG_LIM_PROG: lim_q[0] <= avs_writedata[CW-1:0];
            `WQ_REG_PW_COMP: pw_q[1] <= avs_writedata[CW-1:0];
            `WQ_REG_LIM_COMP: lim_q[1] <= avs_writedata[CW-1:0];
            `WQ_REG_PW_SER: pw_q[2] <= avs_writedata[CW-1:0];
            `WQ_REG_LIM_SER: lim_q[2] <= avs_writedata[CW-1:0];
            `WQ_REG_SEL: sel_q <= avs_writedata[PW-1:0];
            `WQ_REG_DELAY: delay_q <= (avs_writedata[15:0] >
               {3'h0, `WQ_MAX_MS}) ? `WQ_MAX_MS :
               avs_writedata[12:0];
            `WQ_REG_DIP: dip_q <= avs_writedata[VW-1:0];
            // A zero depth would stall the window, so hold at least one
            `WQ_REG_DEPTH: depth_q <= (avs_writedata[15:0] == 16'h0000) ?
               16'h0001 : avs_writedata[15:0];
            default: sp_mode_q <= sp_mode_q;
         endcase
      end
   end

   // Fault counters: one combined update per spot
   always @(posedge clock) begin
      if (rst) begin
         for (i = 0; i < NPROG; i = i + 1)
            prog_cnt_q[i] <= {CW{1'b0}};
         comp_q <= {CW{1'b0}};
         ser_q <= {CW{1'b0}};
         last_prog_q <= {PW{1'b0}};
         prog_reach_q <= 1'b0;
      end else begin
         prog_reach_q <= 1'b0;
         if (spot_done) begin
            prog_cnt_q[spot_prog] <= prog_next;
            last_prog_q <= spot_prog;
            prog_reach_q <= (prog_next == lim_q[0]) &&
               (prog_cnt_q[spot_prog] != lim_q[0]);
         end
         if (soft_clr && avs_writedata[`WQ_CLR_ALL_PROG]) begin
            for (i = 0; i < NPROG; i = i + 1)
               prog_cnt_q[i] <= {CW{1'b0}};
            prog_reach_q <= 1'b0;
         end else if (soft_clr && avs_writedata[`WQ_CLR_ONE_PROG]) begin
            prog_cnt_q[clr_idx] <= {CW{1'b0}};
            if (clr_idx == spot_prog)
               prog_reach_q <= 1'b0;
         end
         if (cnt_clr) begin
            comp_q <= {CW{1'b0}};
            ser_q <= {CW{1'b0}};
         end else begin
            comp_q <= step(comp_q, lim_q[1], spot_fault,
               1'b0);
            ser_q <= step(ser_q, lim_q[2], spot_fault,
               spot_good);
         end
      end
   end

   // Limit outputs and messages; nothing here reaches the weld sequence
   always @(posedge clock) begin
      if (rst) begin
         hit_prev_q <= 2'h0;
         msg_pend_q <= 3'h0;
         limit_out <= 3'h0;
         prewarn_out <= 3'h0;
         msg_valid <= 1'b0;
         msg_code <= 10'h000;
      end else begin
         hit_prev_q <= hit[2:1];
         limit_out <= hit;
         prewarn_out <= warn;
         msg_valid <= |pend_all;
         // New and pending crossings drain in fixed order: program, component, then series
         if (pend_all[0]) begin
            msg_code <= `WQ_MSG_PROG;
            msg_pend_q <= pend_all & 3'h6;
         end else if (pend_all[1]) begin
            msg_code <= `WQ_MSG_COMP;
            msg_pend_q <= pend_all & 3'h5;
         end else if (pend_all[2]) begin
            msg_code <= `WQ_MSG_SER;
            msg_pend_q <= 3'h0;
         end else begin
            msg_code <= msg_code;
            msg_pend_q <= 3'h0;
         end
      end
   end

   // Spatter detection over one process
   always @(posedge clock) begin
      if (rst) begin
         act_prev_q <= 1'b0;
         cur_seen_q <= 1'b0;
         sp_hit_q <= 1'b0;
         sp_at_q <= 13'h0000;
         ms_q <= 13'h0000;
         tick_q <= 16'h0000;
         prev_v_q <= {VW{1'b0}};
         have_prev_q <= 1'b0;
      end else begin
         act_prev_q <= weld_active;
         if (weld_active && !act_prev_q) begin
            cur_seen_q <= 1'b0;
            sp_hit_q <= 1'b0;
            sp_at_q <= 13'h0000;
            ms_q <= 13'h0000;
            // The start edge is the first tick, so ms are not reported late
            tick_q <= 16'h0001;
            have_prev_q <= 1'b0;
         end else if (weld_active) begin
            if (weld_current)
               cur_seen_q <= 1'b1;
            if (tick_q == MS_CYC[15:0] - 16'h0001) begin
               tick_q <= 16'h0000;
               if (ms_q != `WQ_MAX_MS)
                  ms_q <= ms_q + 13'h0001;
            end else begin
               tick_q <= tick_q + 16'h0001;
            end
            if (volt_valid) begin
               prev_v_q <= weld_volt;
               have_prev_q <= 1'b1;
            end
            // Only the first dip past the start delay is recorded
            if (dip && !sp_hit_q && ms_q >= delay_eff) begin
               sp_hit_q <= 1'b1;
               sp_at_q <= ms_q;
            end
         end
      end
   end

   // Spatter statistics per program
   always @(posedge clock) begin
      if (rst) begin
         for (i = 0; i < NPROG; i = i + 1) begin
            proc_q[i] <= 16'h0000;
            spat_q[i] <= 16'h0000;
         end
         sp_report <= 1'b0;
         sp_none <= 1'b1;
         sp_time_ms <= 13'h0000;
         rate_q <= 16'h0000;
      end else begin
         sp_report <= spot_done & sp_eval;
         if (sp_mode_q == `WQ_SP_OFF) begin
            for (i = 0; i < NPROG; i = i + 1)
               spat_q[i] <= 16'h0000;
            rate_q <= 16'h0000;
         end else begin
            rate_q <= rate_div[15:0];
            // Pause fails sp_eval, so counts simply hold
            if (spot_done && sp_eval) begin
               sp_none <= ~sp_hit_q;
               sp_time_ms <= sp_hit_q ? sp_at_q : 13'h0000;
               // At full depth the window halves, keeping the rate
               if (proc_q[spot_prog] < depth_q) begin
                  proc_q[spot_prog] <= proc_q[spot_prog] +
                     16'h0001;
                  spat_q[spot_prog] <= spat_q[spot_prog] +
                     {15'h0000, sp_hit_q};
               end else begin
                  proc_q[spot_prog] <= {1'b0,
                     proc_q[spot_prog][15:1]} + 16'h0001;
                  spat_q[spot_prog] <= {1'b0, spat_q[spot_prog][15:1]} +
                     {15'h0000, sp_hit_q};
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/wq_error_counters_asserts.sv
/*
 Port checker for wq_error_counters.
 Assumes default port widths; bound to every instance.
*/
`timescale 1ns/1ps
`default_nettype none
module wq_error_counters_chk (
   input wire logic clock,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic fault_counter_clear,
   input wire logic spot_done,
   input wire logic [2:0] limit_out,
   input wire logic [2:0] prewarn_out,
   input wire logic msg_valid,
   input wire logic [9:0] msg_code,
   input wire logic sp_report,
   input wire logic sp_none,
   input wire logic [12:0] sp_time_ms
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_reset_idle: assert property (disable iff (1'b0) rst |=>
      !msg_valid && !sp_report && limit_out == 3'h0 && avs_waitrequest)
      else $error("outputs busy after reset");
   a_msg_code_set: assert property (
      msg_valid |-> msg_code inside {10'h18D, 10'h18E, 10'h18F})
      else $error("message code outside the counter set");
   a_comp_limit_msg: assert property (
      $rose(limit_out[1]) |-> ##[0:2] (msg_valid && msg_code == 10'h18E))
      else $error("component limit without message");
   a_ser_limit_msg: assert property (
      $rose(limit_out[2]) |-> ##[0:2] (msg_valid && msg_code == 10'h18F))
      else $error("series limit without message");
   a_msg_one_pulse: assert property (
      msg_valid |=> !msg_valid || msg_code != $past(msg_code))
      else $error("message repeated");
   a_clear_zeroes: assert property (
      fault_counter_clear [*6] |-> limit_out[2:1] == 2'h0
      && prewarn_out[2:1] == 2'h0)
      else $error("counters not held at zero by clear");
   a_time_range: assert property (
      sp_report |-> sp_time_ms <= 13'h1B58)
      else $error("spatter instant out of range");
   a_none_time: assert property (
      sp_report && sp_none |-> sp_time_ms == 13'h0000)
      else $error("spatter instant set with no spatter");
   a_report_spot: assert property (
      sp_report |-> $past(spot_done))
      else $error("spatter result without a spot");
   a_bus_one_wait: assert property (
      (avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus access not ended after one wait");
endmodule
bind wq_error_counters wq_error_counters_chk i_chk (.clock(clock),
   .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .spot_done(spot_done),
   .fault_counter_clear(fault_counter_clear), .limit_out(limit_out),
   .prewarn_out(prewarn_out), .msg_valid(msg_valid), .msg_code(msg_code),
   .sp_report(sp_report), .sp_none(sp_none), .sp_time_ms(sp_time_ms));
`default_nettype wire

// ===== dv/wq_weld_partner.sv
/*
 Model of the monitoring functions and weld sequencer.
 Assumes the bench calls spot and weld just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module wq_weld_partner #(
   parameter int MS = 10
) (
   input wire logic clock,
   output logic spot_done,
   output logic [7:0] mon_fault,
   output logic [3:0] spot_prog,
   output logic weld_active,
   output logic weld_current,
   output logic volt_valid,
   output wire logic [11:0] weld_volt
);
   logic [11:0] volt_q;
   logic [11:0] pat;
   initial begin
      spot_done = 1'b0;
      mon_fault = 8'h00;
      spot_prog = 4'h0;
      weld_active = 1'b0;
      weld_current = 1'b0;
      volt_valid = 1'b0;
      volt_q = 12'h000;
      pat = 12'h000;
   end
   // Stale samples must not look valid, so the bus moves between them
   always @(posedge clock)
      pat <= pat + 12'h3A5;
   assign weld_volt = volt_valid ? volt_q : pat;
   // All monitors' verdicts on one spot arrive in one pulse
   task automatic spot(input logic [7:0] f, input logic [3:0] p);
      @(posedge clock);
      spot_done <= 1'b1;
      mon_fault <= f;
      spot_prog <= p;
      @(posedge clock);
      spot_done <= 1'b0;
      mon_fault <= ~f;
      spot_prog <= ~p;
   endtask
   // A weld of len ms; the voltage dips by 12'h100 at dip ms
   task automatic weld(input logic cur, input int len, input int dip);
      int n;
      @(posedge clock);
      weld_active <= 1'b1;
      weld_current <= cur;
      for (n = 0; n < len * MS; n++) begin
         volt_valid <= 1'b1;
         volt_q <= (n >= dip * MS) ? 12'h700 : 12'h800;
         @(posedge clock);
      end
      weld_active <= 1'b0;
      weld_current <= 1'b0;
      volt_valid <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== dv/wq_error_counters_bench.sv
/*
 Self-checking bench for wq_error_counters.
 Assumes the partner model drives all spot and weld inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module wq_error_counters_bench;
   logic clock, rst, avs_read, avs_write, avs_waitrequest, f;
   logic fault_counter_clear, spot_done, weld_active, weld_current;
   logic volt_valid, msg_valid, sp_report, sp_none, rep_none;
   logic [7:0] avs_address, mon_fault;
   logic [31:0] avs_writedata, avs_readdata, rdata, r;
   logic [3:0] spot_prog, p;
   logic [11:0] weld_volt;
   logic [2:0] limit_out, prewarn_out;
   logic [9:0] msg_code;
   logic [12:0] sp_time_ms, rep_t;
   logic [15:0] pc [16];
   logic [15:0] comp, ser;
   int errors, cmp_count, cycles, reps, nmsg, emsg, seed, i;
   wq_error_counters #(.MS_CYC(10)) i_dut (.clock(clock), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .fault_counter_clear(fault_counter_clear), .mon_fault(mon_fault),
      .spot_done(spot_done), .spot_prog(spot_prog),
      .weld_active(weld_active), .weld_current(weld_current),
      .volt_valid(volt_valid), .weld_volt(weld_volt),
      .limit_out(limit_out), .prewarn_out(prewarn_out),
      .msg_valid(msg_valid), .msg_code(msg_code), .sp_report(sp_report),
      .sp_none(sp_none), .sp_time_ms(sp_time_ms));
   wq_weld_partner #(.MS(10)) i_mon (.clock(clock), .spot_done(spot_done),
      .mon_fault(mon_fault), .spot_prog(spot_prog),
      .weld_active(weld_active), .weld_current(weld_current),
      .volt_valid(volt_valid), .weld_volt(weld_volt));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic summarize;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (sp_report === 1'b1) begin
         reps++;
         rep_t = sp_time_ms;
         rep_none = sp_none;
      end
      if (msg_valid === 1'b1)
         nmsg += 1 << (8 * (msg_code - 10'h18D));
      if (cycles == 20000) begin
         errors++;
         summarize;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h, expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rdata, exp);
   endtask
   // Held past the two-stage synchroniser on both edges
   task automatic clr;
      @(posedge clock);
      fault_counter_clear <= 1'b1;
      repeat (7) @(posedge clock);
      fault_counter_clear <= 1'b0;
      repeat (4) @(posedge clock);
      comp = 16'h0;
      ser = 16'h0;
   endtask
   // Saturating counter step; returns 1 when the limit is newly reached
   function automatic int upd(inout logic [15:0] c, input logic [15:0] l,
         input logic flt, input logic dn);
      logic [15:0] o;
      o = c;
      if (flt)
         c = (c >= l) ? c : c + 16'h1;
      else if (dn && c != 16'h0)
         c = c - 16'h1;
      return int'(c == l && o != l);
   endfunction
   // One weld, its spot, then the spatter result seen for it
   task automatic sw(input logic cur, input int len, input int dip,
         input int n_rep, input logic none, input int t);
      int r0;
      r0 = reps;
      i_mon.weld(cur, len, dip);
      i_mon.spot(8'h00, 4'h1);
      repeat (2) @(posedge clock);
      check(reps - r0, n_rep);
      if (n_rep > 0) begin
         check(32'(rep_none), 32'(none));
         check(rep_t >= t && rep_t <= t + 1, 32'h1);
      end
   endtask
   initial begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      fault_counter_clear = 1'b0;
      comp = 16'h0;
      ser = 16'h0;
      pc = '{default: 16'h0};
      seed = 32'h40DF;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 6; i++)
         rc(8'(4 * i + 4), i[0] ? 32'hA : 32'h5);
      rc(8'h40, 32'h0);
      rc(8'h44, 32'h40);
      rc(8'h48, 32'h64);
      rc(8'hFC, 32'h0);
      for (i = 0; i < 6; i++)
         bus(1'b1, 8'(4 * i + 4), i[0] ? (i == 3 ? 32'h4 : 32'h3) : 32'h2);
      rc(8'h10, 32'h4);
      bus(1'b1, 8'h00, 32'h0300);
      for (i = 0; i < 80; i++) begin
         r = $random(seed);
         p = r[19:16];
         if (r[7:4] == 4'h0) begin
            clr;
         end else if (r[7:4] == 4'h1) begin
            bus(1'b1, 8'h1C, {20'h0, p, 6'h0, ~r[8], r[8]});
            if (r[8])
               pc = '{default: 16'h0};
            else
               pc[p] = 16'h0;
         end else begin
            f = |(r[15:8] & 8'h03);
            i_mon.spot(r[15:8], p);
            // One byte per message code: program, component, series
            emsg += upd(pc[p], 16'h3, f, 1'b1)
               + 256 * upd(comp, 16'h4, f, 1'b0)
               + 65536 * upd(ser, 16'h3, f, 1'b1);
            repeat (2) @(posedge clock);
            check(32'(limit_out), 32'({ser >= 16'h3, comp >= 16'h4,
               pc[p] >= 16'h3}));
            check(32'(prewarn_out), 32'({ser >= 16'h2, comp >= 16'h2,
               pc[p] >= 16'h2}));
         end
         bus(1'b1, 8'h2C, {28'h0, p});
         rc(8'h30, pc[p]);
         rc(8'h24, comp);
         rc(8'h28, ser);
      end
      check(nmsg, emsg);
      clr;
      bus(1'b1, 8'h2C, 32'h1);
      bus(1'b1, 8'h40, 32'h2000);
      rc(8'h40, 32'h1B58);
      bus(1'b1, 8'h40, 32'h5);
      bus(1'b1, 8'h00, 32'h2301);
      sw(1'b1, 10, 7, 1, 1'b0, 7);
      rc(8'h28, 32'h1);
      sw(1'b1, 10, 20, 1, 1'b1, 0);
      rc(8'h34, 32'h2);
      rc(8'h38, 32'h1F4);
      sw(1'b0, 10, 7, 0, 1'b0, 0);
      bus(1'b1, 8'h00, 32'h2302);
      sw(1'b1, 10, 7, 0, 1'b0, 0);
      rc(8'h34, 32'h2);
      rc(8'h38, 32'h1F4);
      bus(1'b1, 8'h00, 32'h2301);
      sw(1'b1, 10, 7, 1, 1'b0, 7);
      rc(8'h34, 32'h3);
      bus(1'b1, 8'h40, 32'h0);
      sw(1'b1, 15, 10, 1, 1'b1, 0);
      bus(1'b1, 8'h00, 32'h2300);
      rc(8'h38, 32'h0);
      summarize;
   end
endmodule
`default_nettype wire
